// ### scc_pkg.sv
package scc_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int RAW_W  = 32;
  localparam int DIFF_W = 14;
  localparam int CM_W   = 8;
  localparam int COMP_W = DIFF_W + CM_W;
  localparam int ACC_W  = RAW_W + 14;
  localparam int CNT_W  = 14;
  localparam int STEP_W = 5;
  // ---------------------------------------------------------------
  // positions and reset values
  // ---------------------------------------------------------------
  localparam logic [STEP_W-1:0] STEP_MSB   = 5'h1f;
  localparam logic [RAW_W-1:0]  RAW_HALF   = 32'h8000_0000;
  localparam logic [CM_W-1:0]   CM_SIGN    = 8'h80;
  localparam logic [RAW_W-1:0]  TRIAL_RST  = 32'h0000_0000;
  localparam int                DIFF_LSB   = RAW_W - DIFF_W;
  // log2 of decimation factor per select pattern {sel0,decim_select_1}
  localparam logic [3:0] SHIFT_00 = 4'h8;
  localparam logic [3:0] SHIFT_01 = 4'ha;
  localparam logic [3:0] SHIFT_10 = 4'hc;
  localparam logic [3:0] SHIFT_11 = 4'he;
  localparam int BUF_DEPTH = 2;
  localparam int CONV_CYC  = 32;

  typedef struct packed {
    logic [DIFF_W-1:0] diff;
    logic [CM_W-1:0]   cm;
  } scc_composite_t;
endpackage

// ### scc_buf.sv
`timescale 1ns/100ps
module scc_buf
  import scc_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = BUF_DEPTH
)(
  input  wire logic         sys_clk,   // clock
  input  wire logic         rstn,      // async reset, low
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // word held
  input  wire logic         out_ready, // drain takes it
  output logic [W-1:0]      out_data   // oldest word
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wp;
  logic [PW:0]  rp;
  logic [PW:0]  next_wp;
  logic [PW:0]  next_rp;
  logic         push;
  logic         pop;

  // ---------------------------------------------------------------
  // pointers, extra bit tells full from empty
  // ---------------------------------------------------------------
  always_comb
  begin
    in_ready  = (wp[PW] == rp[PW]) || (wp[PW-1:0] != rp[PW-1:0]);
    out_valid = (wp != rp);
    out_data  = mem[rp[PW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_wp   = push ? wp + 1'b1 : wp;
    next_rp   = pop ? rp + 1'b1 : rp;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // storage needs no reset, valid is tracked by pointers
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wp[PW-1:0]] <= in_data;
  end
endmodule // scc_buf

// ### scc_decim.sv
`timescale 1ns/100ps
module scc_decim
  import scc_pkg::*;
(
  input  wire logic             sys_clk,    // clock
  input  wire logic             rstn,       // async reset, low
  input  wire logic             in_valid,   // raw code offered
  output logic                  in_ready,   // filter accepts
  input  wire logic [RAW_W-1:0] in_data,    // raw code, signed
  input  wire logic [1:0]       sel,        // strap {sel0,decim_select_1}
  input  wire logic             sync_pulse, // phase reset
  output logic                  out_valid,  // one-cycle pulse
  output logic [RAW_W-1:0]      out_code    // filtered code
);
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] next_acc;
  logic [CNT_W-1:0]        cnt;
  logic [CNT_W-1:0]        next_cnt;
  logic [3:0]              shift;
  logic [3:0]              next_shift;
  logic                    strapped;
  logic                    pend;
  logic                    next_pend;
  logic                    next_valid;
  logic [RAW_W-1:0]        next_code;
  logic [CNT_W-1:0]        last;

  // ---------------------------------------------------------------
  // boxcar average and decimate
  // ---------------------------------------------------------------
  // dump cycle stalls the input; the buffer upstream absorbs it
  always_comb
  begin
    next_shift = shift;
    if (!strapped)
    begin
      unique case (sel)
        2'b00: next_shift = SHIFT_00;
        2'b01: next_shift = SHIFT_01;
        2'b10: next_shift = SHIFT_10;
        2'b11: next_shift = SHIFT_11;
      endcase
    end
    last       = CNT_W'((1 << shift) - 1);
    in_ready   = !pend && strapped;
    next_acc   = acc;
    next_cnt   = cnt;
    next_pend  = pend;
    next_valid = 1'b0;
    next_code  = out_code;
    if (sync_pulse)
    begin
      next_acc  = '0;
      next_cnt  = '0;
      next_pend = 1'b0;
    end
    else if (pend)
    begin
      next_code  = RAW_W'(acc >>> shift);
      next_valid = 1'b1;
      next_acc   = '0;
      next_pend  = 1'b0;
    end
    else if (in_valid && in_ready)
    begin
      next_acc = acc + ACC_W'(signed'(in_data));
      if (cnt == last)
      begin
        next_cnt  = '0;
        next_pend = 1'b1;
      end
      else
        next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc       <= '0;
      cnt       <= '0;
      pend      <= 1'b0;
      shift     <= SHIFT_00;
      strapped  <= 1'b0;
      out_valid <= 1'b0;
      out_code  <= '0;
    end
    else
    begin
      acc       <= next_acc;
      cnt       <= next_cnt;
      pend      <= next_pend;
      shift     <= next_shift;
      strapped  <= 1'b1;
      out_valid <= next_valid;
      out_code  <= next_code;
    end
  end
endmodule // scc_decim

// ### scc_conv.sv
`timescale 1ns/100ps
module scc_conv
  import scc_pkg::*;
(
  input  wire logic             sys_clk,              // 20 MHz clock
  input  wire logic             rstn,                 // async reset, low
  input  wire logic             master_clk,           // conversion start level
  input  wire logic             sync_in,              // filter sync level
  input  wire logic             decim_select_0,       // strap bit 0
  input  wire logic             decim_select_1,       // strap bit 1
  input  wire logic             comp_keep,            // comparator: input >= dac
  input  wire logic [CM_W-1:0]  cm_code,              // common-mode code, offset binary
  input  wire logic             composite_shift_clock, // shift clock level
  output logic                  busy,                 // converting
  output logic                  track,                // sampling array tracks inputs
  output logic [RAW_W-1:0]      sampling_cap_dac,     // trial word to array
  output logic                  filtered_ready_n,     // low: new filtered code
  output logic [RAW_W-1:0]      filtered_code,        // filtered code
  output logic                  composite_serial_out  // composite bit out
);
  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_DONE} scc_state_t;

  scc_state_t         st;
  scc_state_t         next_st;
  logic [STEP_W-1:0]  step;
  logic [STEP_W-1:0]  next_step;
  logic [RAW_W-1:0]   res;
  logic [RAW_W-1:0]   next_res;
  logic [RAW_W-1:0]   next_trial;
  logic               next_busy;
  logic               next_track;
  logic               mclk_q;
  logic               sync_q;
  logic               sck_q;
  logic               mclk_rise;
  logic               sync_rise;
  logic               sck_rise;
  logic               start;
  logic [RAW_W-1:0]   raw_code;
  scc_composite_t     comp_word;
  logic [COMP_W-1:0]  shreg;
  logic [COMP_W-1:0]  next_shreg;
  logic               next_sout;
  logic               next_frdy_n;
  logic               buf_in_ready;
  logic               buf_in_valid;
  logic               flt_valid;
  logic               flt_ready;
  logic [RAW_W-1:0]   flt_data;
  logic               flt_out_valid;
  logic [RAW_W-1:0]   flt_code;
  logic               handoff;

  // ---------------------------------------------------------------
  // edge detection on synchronous pins
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mclk_q <= 1'b0;
      sync_q <= 1'b0;
      sck_q  <= 1'b0;
    end
    else
    begin
      mclk_q <= master_clk;
      sync_q <= sync_in;
      sck_q  <= composite_shift_clock;
    end
  end

  assign mclk_rise = master_clk && !mclk_q;
  assign sync_rise = sync_in && !sync_q;
  assign sck_rise  = composite_shift_clock && !sck_q;
  // edges during a conversion are ignored, the host must not send them
  assign start     = mclk_rise && (st == ST_ACQ);

  // ---------------------------------------------------------------
  // output code forming
  // ---------------------------------------------------------------
  // flip msb to two's complement
  assign raw_code       = {~res[RAW_W-1], res[RAW_W-2:0]};
  // differential top bits, then common mode
  assign comp_word      = {raw_code[RAW_W-1:DIFF_LSB], cm_code ^ CM_SIGN};
  assign handoff        = (st == ST_DONE) && buf_in_ready;
  assign buf_in_valid   = (st == ST_DONE);

  // ---------------------------------------------------------------
  // successive approximation sequencer
  // ---------------------------------------------------------------
  // one bit per clock: 32 steps take 1.6 us, longer than a 1 Msps cycle
  always_comb
  begin
    next_st    = st;
    next_step  = step;
    next_res   = res;
    next_trial = sampling_cap_dac;
    next_busy  = busy;
    next_track = track;
    unique case (st)
      ST_ACQ:
      begin
        if (start)
        begin
          next_busy  = 1'b1;
          next_track = 1'b0;
          next_st    = ST_CONV;
          next_step  = STEP_MSB;
          next_res   = '0;
          next_trial = RAW_HALF;
        end
      end
      ST_CONV:
      begin
        next_res[step] = comp_keep;
        if (step == '0)
        begin
          next_st    = ST_DONE;
          next_trial = next_res;
        end
        else
        begin
          next_step  = step - 1'b1;
          next_trial = next_res | (RAW_W'(1) << (step - 1'b1));
        end
      end
      ST_DONE:
      begin
        // waits here while the buffer is full
        if (handoff)
        begin
          next_busy  = 1'b0;
          next_track = 1'b1;
          next_st    = ST_ACQ;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st               <= ST_ACQ;
      step             <= STEP_MSB;
      res              <= '0;
      sampling_cap_dac <= TRIAL_RST;
      busy             <= 1'b0;
      track            <= 1'b1;
    end
    else
    begin
      st               <= next_st;
      step             <= next_step;
      res              <= next_res;
      sampling_cap_dac <= next_trial;
      busy             <= next_busy;
      track            <= next_track;
    end
  end

  // ---------------------------------------------------------------
  // composite shifter and ready flag
  // ---------------------------------------------------------------
  // load wins over a shift edge in the same cycle
  always_comb
  begin
    next_shreg  = shreg;
    next_sout   = composite_serial_out;
    next_frdy_n = filtered_ready_n;
    if (handoff)
    begin
      next_shreg = comp_word;
      next_sout  = comp_word.diff[DIFF_W-1];
    end
    else if (sck_rise)
    begin
      next_shreg = {shreg[COMP_W-2:0], 1'b0};
      next_sout  = shreg[COMP_W-2];
    end
    if (start)
      next_frdy_n = 1'b1;
    if (flt_out_valid)
      next_frdy_n = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shreg                <= '0;
      composite_serial_out <= 1'b0;
      filtered_ready_n     <= 1'b1;
      filtered_code        <= '0;
    end
    else
    begin
      shreg                <= next_shreg;
      composite_serial_out <= next_sout;
      filtered_ready_n     <= next_frdy_n;
      filtered_code        <= flt_out_valid ? flt_code : filtered_code;
    end
  end

  // ---------------------------------------------------------------
  // raw code path to the filter
  // ---------------------------------------------------------------
  // raw code to filter
  scc_buf #(
    .W     (RAW_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (raw_code),
    .out_valid (flt_valid),
    .out_ready (flt_ready),
    .out_data  (flt_data)
  );

  scc_decim u_decim (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .in_valid   (flt_valid),
    .in_ready   (flt_ready),
    .in_data    (flt_data),
    .sel        ({decim_select_0, decim_select_1}),
    .sync_pulse (sync_rise),
    .out_valid  (flt_out_valid),
    .out_code   (flt_code)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_start;
    (st == ST_ACQ) && mclk_rise;
  endsequence

  // one cycle puts the first trial up, then 32 bit decisions
  sequence s_bits_done;
    ##33 (st == ST_DONE);
  endsequence

  a_busy_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_start |=> busy && !track)
    else $error("busy not raised at conversion start");

  a_start_edge: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_start |=> (st == ST_CONV) && (sampling_cap_dac == RAW_HALF))
    else $error("conversion edge did not start a conversion");

  a_conv_steps: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_start |-> s_bits_done)
    else $error("successive approximation not 32 steps");

  a_busy_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
    handoff |=> !busy && track && (st == ST_ACQ))
    else $error("busy not dropped after conversion");

  a_track_phase: assert property (@(posedge sys_clk) disable iff (!rstn)
    busy == !track)
    else $error("tracking overlaps conversion");

  a_comp_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    handoff |=> shreg == {$past(raw_code[RAW_W-1:DIFF_LSB]), $past(cm_code) ^ CM_SIGN})
    else $error("composite code badly formed");

  a_comp_msb: assert property (@(posedge sys_clk) disable iff (!rstn)
    handoff |=> composite_serial_out == $past(~res[RAW_W-1]))
    else $error("composite msb not presented at end of conversion");

  a_shift_msb: assert property (@(posedge sys_clk) disable iff (!rstn)
    sck_rise && !handoff |=> composite_serial_out == $past(shreg[COMP_W-2]))
    else $error("composite shift out of order");

  a_ready_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
    flt_out_valid |=> !filtered_ready_n && (filtered_code == $past(flt_code)))
    else $error("filtered ready not lowered");

  a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st == ST_CONV) && mclk_rise |=> busy)
    else $error("edge during conversion disturbed it");

  a_raw_handoff: assert property (@(posedge sys_clk) disable iff (!rstn)
    handoff |=> flt_valid)
    else $error("raw code not offered to the filter");

  a_sync_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    sync_rise |=> (u_decim.cnt == '0) && !flt_out_valid)
    else $error("sync pulse did not clear the filter phase");
endmodule // scc_conv

// ### scc_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// host and comparator on the far side of the converter
// ---------------------------------------------------------------
module scc_host_model
  import scc_pkg::*;
(
  input  wire logic              sys_clk,               // bench clock
  input  wire logic [RAW_W-1:0]  sample,                // held input, offset binary
  input  wire logic              busy,                  // converter busy
  input  wire logic [RAW_W-1:0]  sampling_cap_dac,      // trial word
  input  wire logic              composite_serial_out,  // composite bit
  output logic                   master_clk,            // conversion clock
  output logic                   comp_keep,             // comparator result
  output logic                   composite_shift_clock  // shift clock, idle low
);
  // trial compare
  // ideal comparator, so the result equals the held input exactly
  assign comp_keep = (sample >= sampling_cap_dac);

  initial master_clk = 1'b0;
  initial composite_shift_clock = 1'b0;

  // conversion start
  // forced starts ignore busy, only for the refusal scenario
  task automatic pulse_start(input bit forced);
    int n;
    begin
      n = 0;
      while (!forced && busy && n < 200)
      begin
        @(negedge sys_clk);
        n++;
      end
      master_clk = 1'b1;
      @(negedge sys_clk);
      n = 0;
      while (!busy && n < 8)
      begin
        @(negedge sys_clk);
        n++;
      end
      master_clk = 1'b0;
    end
  endtask

  // msb first read
  // shift clock moves only inside a read frame, else stands low
  task automatic read_composite(output logic [COMP_W-1:0] word);
    begin
      word = '0;
      for (int i = 0; i < COMP_W; i++)
      begin
        word = {word[COMP_W-2:0], composite_serial_out};
        if (i < COMP_W - 1)
        begin
          composite_shift_clock = 1'b1;
          @(negedge sys_clk);
          composite_shift_clock = 1'b0;
          repeat (2) @(negedge sys_clk);
        end
      end
    end
  endtask
endmodule // scc_host_model

// ### tb_sar_conversion_control.sv
`timescale 1ns/100ps
module tb_sar_conversion_control;
  import scc_pkg::*;
  // ---------------------------------------------------------------
  // stimulus constants and signals
  // ---------------------------------------------------------------
  localparam logic [RAW_W-1:0] S_POS = 32'h9000_0000;
  localparam logic [RAW_W-1:0] S_NEG = 32'h5000_0002;
  localparam logic [RAW_W-1:0] R_POS = S_POS ^ RAW_HALF;
  localparam logic [RAW_W-1:0] R_NEG = S_NEG ^ RAW_HALF;
  logic              sys_clk, rstn, master_clk, sync_in, comp_keep;
  logic              decim_select_0, decim_select_1, composite_shift_clock;
  logic              busy, track, filtered_ready_n, composite_serial_out;
  logic [CM_W-1:0]   cm_code;
  logic [RAW_W-1:0]  sample, sampling_cap_dac, filtered_code, exp_avg;
  int                errors, cmp_count, busy_len, n_acc, df, conv_idx;

  scc_conv i_scc_conv (
    .sys_clk(sys_clk), .rstn(rstn), .master_clk(master_clk), .sync_in(sync_in),
    .decim_select_0(decim_select_0), .decim_select_1(decim_select_1),
    .comp_keep(comp_keep), .cm_code(cm_code), .composite_shift_clock(composite_shift_clock),
    .busy(busy), .track(track), .sampling_cap_dac(sampling_cap_dac),
    .filtered_ready_n(filtered_ready_n), .filtered_code(filtered_code),
    .composite_serial_out(composite_serial_out)
  );

  scc_host_model i_scc_host_model (
    .sys_clk(sys_clk), .sample(sample), .busy(busy), .sampling_cap_dac(sampling_cap_dac),
    .composite_serial_out(composite_serial_out), .master_clk(master_clk),
    .comp_keep(comp_keep), .composite_shift_clock(composite_shift_clock)
  );

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // busy length, only counted while high so the clear never races
  always @(negedge sys_clk)
    if (busy === 1'b1)
      busy_len <= busy_len + 1;

  // ---------------------------------------------------------------
  // compare, convert and closing tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // one conversion, optional illegal restart and composite read
  task automatic convert(input bit extra, input bit rd);
    logic [RAW_W-1:0]  raw;
    logic [COMP_W-1:0] word;
    int                n;
    begin
      sample = conv_idx[0] ? S_NEG : S_POS;
      raw = sample ^ RAW_HALF;
      busy_len = 0;
      i_scc_host_model.pulse_start(1'b0);
      check(sampling_cap_dac, RAW_HALF);
      check({31'h0, track}, 32'h0);
      if (extra)
      begin
        repeat (10) @(negedge sys_clk);
        i_scc_host_model.pulse_start(1'b1);
      end
      n = 0;
      while (busy && n < 200)
      begin
        @(negedge sys_clk);
        n++;
      end
      check(busy_len, CONV_CYC + 1);
      check({31'h0, track}, 32'h1);
      if (rd)
      begin
        i_scc_host_model.read_composite(word);
        check(word, {raw[RAW_W-1 -: DIFF_W], cm_code ^ CM_SIGN});
      end
      repeat (5) @(negedge sys_clk);
      if (extra)
        check({31'h0, busy}, 32'h0);
      conv_idx++;
      n_acc++;
      check({31'h0, filtered_ready_n}, {31'h0, n_acc % df != 0});
      if (n_acc % df == 0)
        check(filtered_code, exp_avg);
    end
  endtask

  task automatic run_n(input int cnt);
    repeat (cnt) convert(1'b0, 1'b0);
  endtask

  task automatic tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    errors = 0;
    cmp_count = 0;
    busy_len = 0;
    n_acc = 0;
    conv_idx = 0;
    df = 256;
    sys_clk = 1'b0;
    rstn = 1'b0;
    sync_in = 1'b0;
    decim_select_0 = 1'b0;
    decim_select_1 = 1'b0;
    cm_code = 8'h3c;
    sample = S_POS;
    // alternating inputs average to half their signed sum
    exp_avg = 32'(($signed({R_POS[31], R_POS}) + $signed({R_NEG[31], R_NEG})) >>> 1);
    repeat (5) @(negedge sys_clk);
    check({busy, track, filtered_ready_n, composite_serial_out}, 32'h6);
    check(sampling_cap_dac, 32'h0);
    check(filtered_code, 32'h0);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    $display("test reset values done");
    convert(1'b0, 1'b1);
    cm_code = 8'hc5;
    convert(1'b0, 1'b1);
    convert(1'b1, 1'b0);
    $display("test single conversions done");
    run_n(253);
    $display("test factor 256 done");
    run_n(100);
    sync_in = 1'b1;
    repeat (2) @(negedge sys_clk);
    sync_in = 1'b0;
    @(negedge sys_clk);
    n_acc = 0;
    run_n(256);
    $display("test sync realign done");
    rstn = 1'b0;
    decim_select_1 = 1'b1;
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    decim_select_1 = 1'b0;
    df = 1024;
    n_acc = 0;
    run_n(1024);
    $display("test factor 1024 done");
    tally_and_finish;
  end

  // watchdog sized well above the expected run of about 64k cycles
  initial
  begin
    #(64'd95000 * 50);
    $display("test watchdog expired");
    errors++;
    tally_and_finish;
  end
endmodule // tb_sar_conversion_control
